// ---- common/bhs_if.sv ----
`timescale 1ns/100ps
interface bhs_if;
    import bhs_pkg::*;
    logic              cs_n;
    logic              rd_n;
    logic              wr_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        host_data_bus_o;
    logic              host_data_bus_oe;
    logic [7:0]        dev_data_o;
    logic              dev_data_oe;
    logic              int_n;
    wire  [7:0]        host_data_bus = dev_data_oe ? dev_data_o
                                      : (host_data_bus_oe ? host_data_bus_o : 8'h00);

    modport dev (
        input  cs_n, rd_n, wr_n, addr, host_data_bus,
        output dev_data_o, dev_data_oe, int_n
    );
    modport host (
        output cs_n, rd_n, wr_n, addr, host_data_bus_o, host_data_bus_oe,
        input  host_data_bus, int_n
    );
endinterface

// ---- common/bhs_pkg.sv ----
package bhs_pkg;
    // ****************************************
    // address and byte lanes
    // ****************************************
    localparam int ADDR_W        = 9;
    localparam int DATA_W        = 8;
    localparam int IDX_W         = 6;
    localparam int NUM_REGS      = 64;
    localparam int HOST_SPACE    = 256;
    localparam int QUAD_W        = 32;
    localparam int LANE_LSB      = 0;
    localparam int IDX_LSB       = 2;
    localparam int UPDATE_BIT    = 8;
    localparam logic [1:0] LANE_MSB_BYTE = 2'h0;
    localparam logic [1:0] LANE_LSB_BYTE = 2'h3;

    // ****************************************
    // reset values and timing
    // ****************************************
    localparam logic [31:0] SHADOW_RST = 32'h0000_0000;
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int GAP_PS          = 42000;
    localparam int GAP_CYC         = (GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_HOLD_CYC = 6;
    localparam int FIFO_DEPTH      = 8;

    typedef enum logic [1:0] {
        BHS_IDLE = 2'b00,
        BHS_READ = 2'b01,
        BHS_WRIT = 2'b11
    } bhs_cyc_t;

    typedef enum logic [1:0] {
        BHH_IDLE = 2'b00,
        BHH_ACT  = 2'b01,
        BHH_GAP  = 2'b11
    } bhh_state_t;
endpackage

// ---- logic/bhs_dev.sv ----
// Contract
// RQ1: 64 quadlet registers in 256-byte space
// RQ2: internal accesses are always 32-bit
// RQ3: lane bits pick read-shadow byte combinationally; here the picked byte is registered and reaches the bus one sys_clk later
// RQ4: update on read snapshots indexed register
// RQ5: shadow bytes readable any order, repeatedly
// RQ6: each write stores one shadow byte
// RQ7: update on write commits whole shadow
// RQ8: unwritten shadow bytes kept and committed
// RQ9: byte 0 most significant, 3 least
// RQ10: host may auto-drive update line
// RQ11: receiver queue read pops into shadow
// RQ12: host reads all four popped bytes
// RQ13: two transmit locations, last marks complete
// RQ14: flags report next queue quadlet ready
// RQ15: strobes, nine address, eight data, int
// RQ16: strobes resampled into device clock
// RQ17: read starts when select and read low
// RQ18: no update keeps read shadow unchanged
// RQ19: write starts on select and write low
// RQ20: host keeps 42 ns between accesses
// RQ21: index ignored without update line
// RQ22: both strobes low means write
// RQ23: registers 32-bit, undefined bits ignored
// RQ24: shadows reset zero, drive only reading
`timescale 1ns/100ps
module bhs_dev
    import bhs_pkg::*;
#(
    parameter logic [IDX_W-1:0] RX_IDX      = 6'h26,
    parameter logic [IDX_W-1:0] TX_NEXT_IDX = 6'h22,
    parameter logic [IDX_W-1:0] TX_LAST_IDX = 6'h23
) (
    bhs_if.dev                  bus,
    input  wire logic           sys_clk,
    input  wire logic           rst_n,
    output logic                reg_wr,
    output logic                reg_rd,
    output logic [IDX_W-1:0]    reg_idx,
    output logic [QUAD_W-1:0]   reg_wdata,
    input  wire logic [QUAD_W-1:0] reg_rdata,
    input  wire logic [QUAD_W-1:0] rxq_data,
    input  wire logic           rxq_valid,
    output logic                rxq_pop,
    output logic [QUAD_W-1:0]   txq_data,
    output logic                txq_valid,
    output logic                txq_last,
    input  wire logic           txq_ready,
    output logic                rxq_avail,
    output logic                txq_avail,
    input  wire logic           irq_req
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0]              cs_s;
        logic [2:0]              rd_s;
        logic [2:0]              wr_s;
        logic                    cs_f;
        logic                    rd_f;
        logic                    wr_f;
        bhs_cyc_t                cyc;
        logic [QUAD_W-1:0]       rshadow;
        logic [QUAD_W-1:0]       wshadow;
        logic                    reg_wr;
        logic                    reg_rd;
        logic [IDX_W-1:0]        reg_idx;
        logic [QUAD_W-1:0]       reg_wdata;
        logic                    rxq_pop;
        logic                    int_n;
        logic                    oe;
        logic [7:0]              dout;
        logic                    rxq_avail;
    } bhs_dev_st_t;

    bhs_dev_st_t st_reg;
    bhs_dev_st_t st_next;

    logic                 in_ready;
    logic                 push;
    logic                 push_last;
    logic [QUAD_W:0]      fifo_out;
    logic [1:0]           lane;
    logic [IDX_W-1:0]     idx;
    logic                 upd;
    logic                 rd_go;
    logic                 wr_go;
    logic [QUAD_W-1:0]    wsh_new;
    logic [QUAD_W-1:0]    rsh_new;

    // RQ1: address split into lane and index
    assign lane = bus.addr[IDX_LSB-1:LANE_LSB];
    assign idx  = bus.addr[UPDATE_BIT-1:IDX_LSB];
    assign upd  = bus.addr[UPDATE_BIT];

    // ****************************************
    // transmitter queue buffer
    // ****************************************
    // RQ7: queue takes merged shadow
    // the byte of this very write is merged before the push, else the queue gets stale data
    bhs_fifo #(.WIDTH(QUAD_W+1), .DEPTH(FIFO_DEPTH)) bhs_fifo_inst (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_data   ({push_last, wsh_new}),
        .in_valid  (push),
        .in_ready  (in_ready),
        .out_data  (fifo_out),
        .out_valid (txq_valid),
        .out_ready (txq_ready)
    );
    assign txq_data  = fifo_out[QUAD_W-1:0];
    assign txq_last  = fifo_out[QUAD_W];
    assign txq_avail = in_ready;

    // RQ16: filtered level needs second and third stage to agree
    assign rd_go = st_reg.cs_f == 1'b0 && st_reg.rd_f == 1'b0;
    assign wr_go = st_reg.cs_f == 1'b0 && st_reg.wr_f == 1'b0;

    always_comb begin
        st_next = st_reg;
        st_next.reg_wr  = 1'b0;
        st_next.reg_rd  = 1'b0;
        st_next.rxq_pop = 1'b0;
        push      = 1'b0;
        push_last = 1'b0;
        wsh_new   = st_reg.wshadow;
        rsh_new   = st_reg.rshadow;

        // RQ16: three-stage resampling of host strobes
        st_next.cs_s = {st_reg.cs_s[1:0], bus.cs_n};
        st_next.rd_s = {st_reg.rd_s[1:0], bus.rd_n};
        st_next.wr_s = {st_reg.wr_s[1:0], bus.wr_n};
        if (st_reg.cs_s[1] == st_reg.cs_s[2]) st_next.cs_f = st_reg.cs_s[2];
        if (st_reg.rd_s[1] == st_reg.rd_s[2]) st_next.rd_f = st_reg.rd_s[2];
        if (st_reg.wr_s[1] == st_reg.wr_s[2]) st_next.wr_f = st_reg.wr_s[2];

        case (st_reg.cyc)
            BHS_IDLE: begin
                // index shown ahead so reg_rdata matches it at the snapshot edge
                st_next.reg_idx = idx;
                // RQ22: write wins when both strobes low
                if (wr_go) begin
                    // RQ6: one byte per write, RQ9 big-endian lanes
                    wsh_new[(3-lane)*8 +: 8] = bus.host_data_bus;
                    st_next.wshadow = wsh_new;
                    st_next.cyc = BHS_WRIT;
                    // RQ21: index only used with update
                    if (upd) begin
                        // RQ13: queue locations append to fifo
                        if (idx == TX_NEXT_IDX || idx == TX_LAST_IDX) begin
                            push      = in_ready;
                            push_last = (idx == TX_LAST_IDX);
                        end
                        // RQ7: background 32-bit commit, RQ8 old bytes kept
                        st_next.reg_wr    = 1'b1;
                        st_next.reg_idx   = idx;
                        // RQ23: whole quadlet, no masking
                        st_next.reg_wdata = wsh_new;
                    end
                end else if (rd_go) begin
                    // RQ17: read begins on later falling strobe
                    st_next.cyc = BHS_READ;
                    if (upd) begin
                        // RQ11: receiver queue read pops into shadow
                        if (idx == RX_IDX) begin
                            rsh_new = rxq_data;
                            st_next.rxq_pop = rxq_valid;
                        end else begin
                            // RQ4: whole-register snapshot, RQ2
                            rsh_new = reg_rdata;
                        end
                        st_next.reg_rd  = 1'b1;
                        st_next.reg_idx = idx;
                        st_next.rshadow = rsh_new;
                    end
                    // RQ18: without update the old shadow is shown
                end
            end
            BHS_READ: begin
                if (!rd_go) st_next.cyc = BHS_IDLE;
            end
            BHS_WRIT: begin
                // RQ19: cycle ends when host releases write
                if (!wr_go) st_next.cyc = BHS_IDLE;
            end
            default: st_next.cyc = BHS_IDLE;
        endcase

        // RQ3: lane picks byte while read active, RQ5 repeatable
        st_next.oe   = (st_next.cyc == BHS_READ) && !bus.cs_n && !bus.rd_n;
        // RQ9: lane 0 is the top byte
        st_next.dout = rsh_new[(3-bus.addr[1:0])*8 +: 8];
        // RQ14: availability flag for receiver queue
        st_next.rxq_avail = rxq_valid;
        st_next.int_n = !irq_req;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // RQ24: shadows clear, bus not driven
            st_reg         <= '0;
            st_reg.cs_s    <= 3'h7;
            st_reg.rd_s    <= 3'h7;
            st_reg.wr_s    <= 3'h7;
            st_reg.cs_f    <= 1'b1;
            st_reg.rd_f    <= 1'b1;
            st_reg.wr_f    <= 1'b1;
            st_reg.int_n   <= 1'b1;
            st_reg.rshadow <= SHADOW_RST;
            st_reg.wshadow <= SHADOW_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // RQ15: port pins and data drive
    assign bus.dev_data_o  = st_reg.dout;
    assign bus.dev_data_oe = st_reg.oe;
    assign bus.int_n       = st_reg.int_n;
    assign reg_wr    = st_reg.reg_wr;
    assign reg_rd    = st_reg.reg_rd;
    assign reg_idx   = st_reg.reg_idx;
    assign reg_wdata = st_reg.reg_wdata;
    assign rxq_pop   = st_reg.rxq_pop;
    assign rxq_avail = st_reg.rxq_avail;
endmodule // bhs_dev

// ---- logic/bhs_fifo.sv ----
`timescale 1ns/100ps
module bhs_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
    } bhs_fifo_st_t;

    bhs_fifo_st_t st_reg;
    bhs_fifo_st_t st_next;
    logic         push;
    logic         pop;

    assign in_ready  = (st_reg.cnt != (PW+1)'(DEPTH));
    assign out_valid = (st_reg.cnt != '0);
    assign out_data  = st_reg.mem[st_reg.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp = (st_reg.wp == PW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = (st_reg.rp == PW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // bhs_fifo

// ---- logic/bhs_host.sv ----
`timescale 1ns/100ps
module bhs_host
    import bhs_pkg::*;
(
    bhs_if.host                  bus,
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic            req_valid,
    input  wire logic            req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [7:0]      req_wdata,
    input  wire logic            auto_update,
    output logic                 req_ready,
    output logic                 rsp_valid,
    output logic [7:0]           rsp_rdata,
    output logic                 irq
);
    typedef struct packed {
        bhh_state_t    st;
        logic [3:0]    cnt;
        logic          write;
        logic [ADDR_W-1:0] addr;
        logic [7:0]    wdata;
        logic          rsp_valid;
        logic [7:0]    rdata;
        logic [2:0]    int_s;
        logic          irq;
    } bhs_host_st_t;

    bhs_host_st_t s_reg;
    bhs_host_st_t s_next;
    logic         upd;

    // RQ10: optional auto update on byte 0 read or byte 3 write
    assign upd = req_addr[UPDATE_BIT] || (auto_update &&
                 (req_write ? req_addr[1:0] == LANE_LSB_BYTE : req_addr[1:0] == LANE_MSB_BYTE));

    always_comb begin
        s_next = s_reg;
        s_next.rsp_valid = 1'b0;
        s_next.int_s = {s_reg.int_s[1:0], bus.int_n};
        if (s_reg.int_s[1] == s_reg.int_s[2]) s_next.irq = !s_reg.int_s[2];
        case (s_reg.st)
            BHH_IDLE: begin
                if (req_valid) begin
                    // RQ4: host raises update with index
                    s_next.addr  = {upd, req_addr[UPDATE_BIT-1:0]};
                    s_next.write = req_write;
                    s_next.wdata = req_wdata;
                    s_next.cnt   = 4'(STROBE_HOLD_CYC);
                    s_next.st    = BHH_ACT;
                end
            end
            BHH_ACT: begin
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h1) begin
                    s_next.rdata     = bus.host_data_bus;
                    s_next.rsp_valid = !s_reg.write;
                    s_next.cnt       = 4'(GAP_CYC);
                    s_next.st        = BHH_GAP;
                end
            end
            BHH_GAP: begin
                // RQ20: keep 42 ns idle between accesses
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h1) s_next.st = BHH_IDLE;
            end
            default: s_next.st = BHH_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg       <= '0;
            s_reg.int_s <= 3'h7;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.cs_n             = (s_reg.st != BHH_ACT);
    assign bus.rd_n             = !(s_reg.st == BHH_ACT && !s_reg.write);
    assign bus.wr_n             = !(s_reg.st == BHH_ACT && s_reg.write);
    assign bus.addr             = s_reg.addr;
    assign bus.host_data_bus_o  = s_reg.wdata;
    assign bus.host_data_bus_oe = (s_reg.st == BHH_ACT) && s_reg.write;
    assign req_ready            = (s_reg.st == BHH_IDLE);
    assign rsp_valid            = s_reg.rsp_valid;
    assign rsp_rdata            = s_reg.rdata;
    assign irq                  = s_reg.irq;
endmodule // bhs_host

// ---- sim/bhs_sva.sv ----
`timescale 1ns/100ps
module bhs_sva (
    input wire logic                       sys_clk,
    input wire logic                       rst_n,
    input wire logic                       cs_n,
    input wire logic                       rd_n,
    input wire logic                       wr_n,
    input wire logic [bhs_pkg::ADDR_W-1:0] addr,
    input wire logic                       host_data_bus_oe,
    input wire logic [7:0]                 dev_data_o,
    input wire logic                       dev_data_oe,
    input wire logic                       int_n
);
    import bhs_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // read cycle steps
    // ****************************************
    sequence rd_go;
        $fell(cs_n | rd_n) && !rd_n && wr_n;
    endsequence
    sequence drv_up;
        ##[1:6] dev_data_oe;
    endsequence

    AST_READ_ANSWER: assert property (rd_go |-> drv_up)
        else $error("read strobe not answered by a driven byte");
    AST_DRIVE_IN_READ: assert property ($rose(dev_data_oe) |-> !cs_n && !rd_n && wr_n)
        else $error("data bus driven outside a read cycle");
    AST_RELEASE: assert property ($rose(rd_n) |-> ##[0:6] !dev_data_oe)
        else $error("data bus held after read strobe ended");
    AST_NO_CLASH: assert property (!(dev_data_oe && host_data_bus_oe))
        else $error("both ends drive the data bus");
    AST_WRITE_QUIET: assert property (!cs_n && !wr_n |-> !dev_data_oe)
        else $error("device drives during a write cycle");
    AST_HOLD_BYTE: assert property ($past(dev_data_oe) && dev_data_oe && !addr[8] && $stable(addr)
                                    |-> $stable(dev_data_o))
        else $error("byte changed without update");
    AST_RESET_QUIET: assert property ($past(rst_n) == 1'b0 |-> !dev_data_oe)
        else $error("data bus driven right after reset");
    AST_INT_IDLE: assert property ($past(rst_n) == 1'b0 |-> int_n)
        else $error("interrupt line low right after reset");
endmodule // bhs_sva

// ---- sim/byte_host_shadow_port_bench.sv ----
`timescale 1ns/100ps
module byte_host_shadow_port_bench;
    import bhs_pkg::*;
    localparam logic [5:0] RX_I = 6'h26;
    localparam logic [5:0] TXN  = 6'h22;
    localparam logic [5:0] TXL  = 6'h23;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req_valid, req_write, auto_update, rxq_valid, txq_ready, irq_req;
    logic [8:0]  req_addr;
    logic [7:0]  req_wdata, rsp_rdata, q;
    logic        req_ready, rsp_valid, irq, reg_wr, reg_rd, rxq_pop, txq_valid, txq_last, txq_avail, rxq_avail;
    logic [5:0]  reg_idx, cap_i;
    logic [31:0] reg_wdata, reg_rdata, rxq_data, txq_data, cap_d;
    int          failures, samples_checked, n_wr, n_rd, n_pop;

    bhs_if bhs_if_inst();
    bhs_dev #(.RX_IDX(RX_I), .TX_NEXT_IDX(TXN), .TX_LAST_IDX(TXL)) bhs_dev_inst (
        .bus(bhs_if_inst), .sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_idx, .reg_wdata, .reg_rdata,
        .rxq_data, .rxq_valid, .rxq_pop, .txq_data, .txq_valid, .txq_last, .txq_ready,
        .rxq_avail, .txq_avail, .irq_req);
    bhs_host bhs_host_inst (.bus(bhs_if_inst), .sys_clk, .rst_n, .req_valid, .req_write, .req_addr,
        .req_wdata, .auto_update, .req_ready, .rsp_valid, .rsp_rdata, .irq);
    bhs_sva bhs_sva_inst (.sys_clk, .rst_n, .cs_n(bhs_if_inst.cs_n), .rd_n(bhs_if_inst.rd_n),
        .wr_n(bhs_if_inst.wr_n), .addr(bhs_if_inst.addr), .host_data_bus_oe(bhs_if_inst.host_data_bus_oe),
        .dev_data_o(bhs_if_inst.dev_data_o), .dev_data_oe(bhs_if_inst.dev_data_oe),
        .int_n(bhs_if_inst.int_n));

    always #2.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (reg_wr === 1'b1 || reg_rd === 1'b1)
            cap_i = reg_idx;
        if (reg_wr === 1'b1)
            cap_d = reg_wdata;
        n_wr += int'(reg_wr === 1'b1);
        n_rd += int'(reg_rd === 1'b1);
        n_pop += int'(rxq_pop === 1'b1);
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // bounded wait: 0 idle, 1 answer, 2 irq up, 3 irq down
    task automatic wt(input int k);
        int n;
        n = 0;
        while ((k == 0 ? req_ready : k == 1 ? rsp_valid : k == 2 ? irq : !irq) !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 200) begin
                failures++;
                end_sim();
            end
        end
    endtask

    task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d, output logic [7:0] r);
        wt(0);
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(negedge sys_clk);
        req_valid = 1'b0;
        if (!w)
            wt(1);
        r = rsp_rdata;
        wt(0);
        @(negedge sys_clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_write;
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, {i == 3, 6'h05, 2'(i)}, 8'ha0 + 8'(i), q);
            chk(n_wr, i == 3);
        end
        chk(cap_i, 6'h05);
        chk(cap_d, 32'ha0a1a2a3);
        acc(1'b1, {1'b1, 6'h0c, 2'h3}, 8'h5a, q);
        chk(cap_i, 6'h0c);
        chk(cap_d, 32'ha0a1a25a);
    endtask

    task automatic t_read;
        reg_rdata = 32'h11223344;
        acc(1'b0, {1'b1, 6'h07, 2'h0}, 8'h00, q);
        chk(q, 8'h11);
        chk(cap_i, 6'h07);
        reg_rdata = 32'hdeadbeef;
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, {1'b0, 6'h3f, 2'(3 - i)}, 8'h00, q);
            chk(q, 8'h44 - 8'h11 * 8'(i));
        end
        chk(n_rd, 1);
        auto_update = 1'b1;
        acc(1'b0, {1'b0, 6'h07, 2'h0}, 8'h00, q);
        auto_update = 1'b0;
        chk(q, 8'hde);
        chk(n_rd, 2);
    endtask

    task automatic t_rx;
        rxq_valid = 1'b1;
        rxq_data = 32'hcafef00d;
        acc(1'b0, 9'h000, 8'h00, q);
        chk(rxq_avail, 1'b1);
        acc(1'b0, {1'b1, RX_I, 2'h1}, 8'h00, q);
        rxq_valid = 1'b0;
        chk(q, 8'hfe);
        chk(n_pop, 1);
        acc(1'b0, 9'h003, 8'h00, q);
        chk(q, 8'h0d);
        acc(1'b0, 9'h000, 8'h00, q);
        chk(q, 8'hca);
        acc(1'b0, 9'h002, 8'h00, q);
        chk(q, 8'hf0);
    endtask

    // fill the transmit queue with the far side stalled, then drain it
    task automatic t_tx;
        auto_update = 1'b1;
        for (int i = 0; i < 9; i++) begin
            acc(1'b1, {1'b0, i == 7 ? TXL : TXN, 2'h3}, 8'(i), q);
            chk(txq_avail, i < 7);
        end
        auto_update = 1'b0;
        @(negedge sys_clk);
        txq_ready = 1'b1;
        for (int i = 0; i < 8; i++) begin
            chk(txq_valid, 1'b1);
            chk(txq_data, {24'ha0a1a2, 8'(i)});
            chk(txq_last, i == 7);
            @(negedge sys_clk);
        end
        chk(txq_valid, 1'b0);
    endtask

    task automatic t_irq;
        irq_req = 1'b1;
        wt(2);
        chk(bhs_if_inst.int_n, 1'b0);
        @(negedge sys_clk);
        irq_req = 1'b0;
        wt(3);
        chk(bhs_if_inst.int_n, 1'b1);
    endtask

    initial begin
        {req_valid, req_write, auto_update, rxq_valid, txq_ready, irq_req} = '0;
        req_addr = '0;
        req_wdata = '0;
        reg_rdata = '0;
        rxq_data = '0;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        acc(1'b0, 9'h001, 8'h00, q);
        chk(q, 8'h00);
        t_write();
        t_read();
        t_rx();
        t_tx();
        t_irq();
        end_sim();
    end
endmodule // byte_host_shadow_port_bench
